// ### rtl/rai_pkg.sv
// Constants for the transmit yellow alarm generator.
// Assumes a transmit framer that supplies frame, bit and data-link timing strobes.
package rai_pkg;
   localparam logic [15:0] ALARM_GEN_CTRL_ADDR = 16'h0108;
   localparam int          RULE_BIT            = 7;
   localparam int          ENABLE_BIT          = 6;
   localparam int          SEL_HI_BIT          = 5;
   localparam int          SEL_LO_BIT          = 4;
   localparam logic [7:0]  CTRL_RESET          = 8'h00;
   localparam logic [7:0]  PATTERN_RUN         = 8'hff;   // 255 patterns
   localparam logic [15:0] PATTERN_HALF        = 16'hff00;
   localparam logic [15:0] PATTERN_ONES        = 16'hffff;
   localparam int          FRAMES_PER_SECOND   = 8000;    // 125 us frames
   localparam logic [3:0]  SF_FRAME_RAI        = 4'hb;    // frame 12, index 11 counted from 0

   typedef enum logic [1:0] {
      FRAMING_SF,
      FRAMING_ESF,
      FRAMING_N,
      FRAMING_DATA_MUX
   } framing_type;
endpackage

// ### rtl/t1_yellow_alarm_generator.sv
// Transmit T1 yellow alarm generator: control register and alarm insertion.
// Assumes framer strobes are one-cycle pulses synchronous to ref_clk_in.
`timescale 1ns/1ns
module t1_yellow_alarm_generator
   import rai_pkg::*;
#(
   parameter int SECOND_FRAMES = FRAMES_PER_SECOND
) (
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   input  wire logic [1:0]  framing_in,
   input  wire logic        frame_start_in,
   input  wire logic [3:0]  sf_frame_in,
   input  wire logic        fs_bit_in,
   input  wire logic        data_bit_in,
   input  wire logic        data_bit_is_b2_in,
   input  wire logic        dl_bit_slot_in,
   input  wire logic        sync_y_bit_in,
   input  wire logic        sync_y_slot_in,
   output logic             fs_bit_out,
   output logic             data_bit_out,
   output logic             dl_bit_out,
   output logic             dl_bit_valid_out,
   output logic             sync_y_bit_out,
   output logic             rai_active_out
);

   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_HOLDOFF} rai_state_type;

   logic [7:0]    ctrl_q;
   rai_state_type state_q, state_d;
   logic [7:0]    pat_cnt_q, pat_cnt_d;
   logic [3:0]    bit_idx_q;
   logic [13:0]   sec_cnt_q, sec_cnt_d;
   logic          ctl_prev_q;
   logic [1:0]    run_sel_q;
   logic [7:0]    rdata_q;

   wire logic       rule_on   = ctrl_q[RULE_BIT];
   wire logic [1:0] sel       = {ctrl_q[SEL_HI_BIT], ctrl_q[SEL_LO_BIT]};
   wire framing_type framing  = framing_type'(framing_in);
   wire logic       is_esf    = (framing == FRAMING_ESF);
   wire logic       hit       = (addr_in == ALARM_GEN_CTRL_ADDR);

   // Controlling bit: enable bit if enforced, else the select bit that times the code
   wire logic ctl_bit = rule_on ? ctrl_q[ENABLE_BIT]
                      : (sel == 2'h2) ? ctrl_q[SEL_HI_BIT] : ctrl_q[SEL_LO_BIT];
   wire logic ctl_rise = ctl_bit & ~ctl_prev_q;
   wire logic sel_on   = (sel != 2'h0);
   // Codes 01 and 11 run the counted pattern; code 10 follows its bit level
   function automatic logic is_timed(input logic [1:0] code);
      return (code == 2'h1) || (code == 2'h3);
   endfunction

   // Non-enforced: clearing the select field ends the pulse, the run keeps its format
   wire logic [1:0] eff_sel = (state_q == ST_SEND && !rule_on && !sel_on) ? run_sel_q : sel;
   wire logic timed    = is_timed(eff_sel);
   wire logic pat_end  = dl_bit_slot_in & (bit_idx_q == 4'hf);
   wire logic sec_done = (sec_cnt_q == 14'(SECOND_FRAMES - 1)) & frame_start_in;

   // Generic alarm state for all ESF codes, code 10 included; other framings follow ctl_bit directly
   always_comb begin
      state_d   = state_q;
      pat_cnt_d = pat_cnt_q;
      sec_cnt_d = sec_cnt_q;
      case (state_q)
         ST_IDLE: begin
            if (ctl_rise && sel_on) begin
               state_d   = ST_SEND;
               pat_cnt_d = 8'h00;
            end
         end
         ST_SEND: begin
            if (!sel_on && rule_on) begin
               state_d = ST_IDLE;
            end else if (ctl_rise) begin
               pat_cnt_d = 8'h00;
            end else if (!timed) begin
               if (!ctl_bit) state_d = ST_IDLE;
            end else if (pat_end) begin
               if (pat_cnt_q != PATTERN_RUN) pat_cnt_d = pat_cnt_q + 8'h01;
               if (pat_cnt_q >= PATTERN_RUN - 8'h01 && !ctl_bit) begin
                  state_d = rule_on ? ST_HOLDOFF : ST_IDLE;
                  sec_cnt_d = 14'h0000;
               end
            end else if (pat_cnt_q == PATTERN_RUN && !ctl_bit) begin
               state_d   = rule_on ? ST_HOLDOFF : ST_IDLE;
               sec_cnt_d = 14'h0000;
            end
         end
         ST_HOLDOFF: begin
            if (frame_start_in) sec_cnt_d = sec_cnt_q + 14'h0001;
            if (sec_done || !rule_on) begin
               // Enable still high after the gap starts the held-off alarm
               state_d   = (rule_on && ctl_bit && sel_on) ? ST_SEND : ST_IDLE;
               pat_cnt_d = 8'h00;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // In SF, N and data-mux framing the alarm follows the control bit level
   wire logic level_alarm = sel_on & ctl_bit & ~(rule_on & (state_q == ST_HOLDOFF));
   wire logic esf_alarm   = (state_q == ST_SEND) & (eff_sel != 2'h0);
   wire logic alarm       = is_esf ? esf_alarm : level_alarm;
   wire logic [15:0] pattern = (eff_sel == 2'h3) ? PATTERN_ONES : PATTERN_HALF;

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_q     <= CTRL_RESET;
         state_q    <= ST_IDLE;
         pat_cnt_q  <= 8'h00;
         bit_idx_q  <= 4'h0;
         sec_cnt_q  <= 14'h0000;
         ctl_prev_q <= 1'b0;
         run_sel_q  <= 2'h0;
         rdata_q    <= 8'h00;
      end else begin
         if (wr_in && hit) ctrl_q <= wdata_in;
         rdata_q    <= (rd_in && hit) ? ctrl_q : 8'h00;
         state_q    <= is_esf ? state_d : (state_q == ST_HOLDOFF ? state_d : ST_IDLE);
         pat_cnt_q  <= pat_cnt_d;
         sec_cnt_q  <= sec_cnt_d;
         ctl_prev_q <= ctl_bit;
         if (ctl_rise && sel_on) run_sel_q <= sel;
         if (dl_bit_slot_in) bit_idx_q <= bit_idx_q + 4'h1;
         if (state_q != ST_SEND && state_d == ST_SEND) bit_idx_q <= 4'h0;
      end
   end

   // Output stage: registered overrides of framer bits
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fs_bit_out       <= 1'b0;
         data_bit_out     <= 1'b0;
         dl_bit_out       <= 1'b1;
         dl_bit_valid_out <= 1'b0;
         sync_y_bit_out   <= 1'b1;
         rai_active_out   <= 1'b0;
      end else begin
         fs_bit_out     <= (alarm && framing == FRAMING_SF && sel == 2'h2
                            && sf_frame_in == SF_FRAME_RAI) ? 1'b1 : fs_bit_in;
         data_bit_out   <= (alarm && data_bit_is_b2_in && !is_esf && sel != 2'h2
                            && framing != FRAMING_DATA_MUX) ? 1'b0 : data_bit_in;
         sync_y_bit_out <= (alarm && sync_y_slot_in && framing == FRAMING_DATA_MUX)
                            ? 1'b0 : sync_y_bit_in;
         dl_bit_out     <= esf_alarm ? pattern[4'hf - bit_idx_q] : 1'b1;
         dl_bit_valid_out <= esf_alarm & dl_bit_slot_in & is_esf;
         rai_active_out <= alarm;
      end
   end

   assign rdata_out = rdata_q;

   // Steps of the counted alarm, each used by one check: the start check or the holdoff check
   sequence seq_start_req;
      ctl_rise && sel_on && state_q == ST_IDLE && is_esf;
   endsequence

   sequence seq_in_send;
      state_q == ST_SEND;
   endsequence

   sequence seq_holdoff_wait;
      state_q == ST_HOLDOFF && rule_on && !frame_start_in;
   endsequence

   sequence seq_in_holdoff;
      state_q == ST_HOLDOFF;
   endsequence

   chk_write_lands: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (wr_in && hit) |=> ctrl_q == $past(wdata_in))
      else $error("Register write lost");

   chk_read_returns: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (rd_in && hit) |=> rdata_out == $past(ctrl_q))
      else $error("Read data wrong");

   chk_read_idle_zero: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      !(rd_in && hit) |=> rdata_out == 8'h00)
      else $error("Read data not zero");

   chk_start_enters_send: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      seq_start_req |=> seq_in_send)
      else $error("Alarm did not start");

   chk_select_zero_quiet: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (eff_sel == 2'h0) |=> !rai_active_out)
      else $error("Alarm sent with select zero");

   chk_dl_idle_ones: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      !esf_alarm |=> dl_bit_out)
      else $error("Data link not idle");

   chk_b2_forced: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (alarm && data_bit_is_b2_in && framing == FRAMING_SF && sel == 2'h1) |=> !data_bit_out)
      else $error("Bit 2 not forced");

   chk_b2_passes: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      !data_bit_is_b2_in |=> data_bit_out == $past(data_bit_in))
      else $error("Data bit altered");

   chk_esf_b2_untouched: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      is_esf |=> data_bit_out == $past(data_bit_in))
      else $error("Data bit altered in ESF");

   chk_no_send_unframed: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (!is_esf && state_q != ST_HOLDOFF) |=> state_q != ST_SEND)
      else $error("Pattern run outside ESF");

   chk_y_bit_forced: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (alarm && sync_y_slot_in && framing == FRAMING_DATA_MUX) |=> !sync_y_bit_out)
      else $error("Y bit not forced");

   chk_y_slot_only: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      !sync_y_slot_in |=> sync_y_bit_out == $past(sync_y_bit_in))
      else $error("Y bit altered outside slot");

   chk_y_untouched_other: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (framing != FRAMING_DATA_MUX) |=> sync_y_bit_out == $past(sync_y_bit_in))
      else $error("Y bit altered in other framing");

   chk_short_pulse_full: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (esf_alarm && is_esf && timed && pat_cnt_q < PATTERN_RUN - 8'h01 && !ctl_rise
       && !(wr_in && hit)) |=> esf_alarm)
      else $error("Alarm shorter than 255 patterns");

   chk_half_pattern_ones: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (esf_alarm && dl_bit_slot_in && eff_sel == 2'h1 && !bit_idx_q[3]) |=> dl_bit_out)
      else $error("Pattern first half not ones");

   chk_half_pattern_zeros: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (esf_alarm && dl_bit_slot_in && eff_sel == 2'h1 && bit_idx_q[3]) |=> !dl_bit_out)
      else $error("Pattern second half not zeros");

   chk_long_pulse_holds: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (esf_alarm && is_esf && ctl_bit && sel_on && !(wr_in && hit)) |=> esf_alarm)
      else $error("Alarm ended while control high");

   chk_rise_restarts: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (state_q == ST_SEND && sel_on && ctl_rise && is_esf) |=> pat_cnt_q == 8'h00)
      else $error("Counter not restarted");

   chk_fs_frame_twelve: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (alarm && framing == FRAMING_SF && sel == 2'h2 && sf_frame_in == SF_FRAME_RAI)
      |=> fs_bit_out)
      else $error("Fs bit not set");

   chk_fs_passes_other: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (sf_frame_in != SF_FRAME_RAI) |=> fs_bit_out == $past(fs_bit_in))
      else $error("Fs bit altered in other frame");

   chk_fs_untouched_esf: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      is_esf |=> fs_bit_out == $past(fs_bit_in))
      else $error("Fs bit altered in ESF");

   chk_code_ten_ends: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (esf_alarm && is_esf && !is_timed(eff_sel) && !ctl_bit) |=> !esf_alarm)
      else $error("Level alarm outlived its bit");

   chk_level_follows: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (!is_esf && sel_on && ctl_bit && state_q != ST_HOLDOFF) |=> rai_active_out)
      else $error("Level alarm missing");

   chk_code_eleven_b2: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (alarm && data_bit_is_b2_in && framing == FRAMING_SF && sel == 2'h3) |=> !data_bit_out)
      else $error("Bit 2 not forced for code 11");

   chk_ones_pattern: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (esf_alarm && dl_bit_slot_in && eff_sel == 2'h3) |=> dl_bit_out)
      else $error("Ones pattern broken");

   chk_holdoff_no_alarm: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (state_q == ST_HOLDOFF) |-> !esf_alarm)
      else $error("Alarm during holdoff");

   chk_holdoff_waits: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      seq_holdoff_wait |=> seq_in_holdoff)
      else $error("Holdoff left early");

   chk_holdoff_only_enforced: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (state_q == ST_HOLDOFF && !rule_on) |=> state_q == ST_IDLE)
      else $error("Holdoff without enforced rule");

   chk_counter_steps: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (state_q == ST_SEND && (sel_on || !rule_on) && !ctl_rise && timed && pat_end
       && pat_cnt_q != PATTERN_RUN) |=> pat_cnt_q == $past(pat_cnt_q) + 8'h01)
      else $error("Pattern counter did not step");

   chk_counter_caps: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (pat_cnt_q == PATTERN_RUN) |=> (pat_cnt_q == PATTERN_RUN || pat_cnt_q == 8'h00))
      else $error("Pattern counter wrapped");

   chk_sec_count_steps: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (state_q == ST_HOLDOFF && frame_start_in) |=> sec_cnt_q == $past(sec_cnt_q) + 14'h0001)
      else $error("Second timer did not step");

   chk_valid_on_slot: assert property (
      @(posedge ref_clk_in) disable iff (!rstn_in)
      (esf_alarm && is_esf && dl_bit_slot_in) |=> dl_bit_valid_out)
      else $error("Pattern bit not marked valid");
endmodule // t1_yellow_alarm_generator

// ### test/rai_far_end.sv
// Far-end model: framer timing strobes and data-link pattern collector.
// Assumes it shares the generator clock and reset.
`timescale 1ns/1ns
module rai_far_end (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        clr_in,
   input  wire logic        dl_bit_in,
   input  wire logic        dl_valid_in,
   output logic             slot_out,
   output logic             frame_out,
   output logic [15:0]      word_out,
   output logic [8:0]       words_out
);
   logic [4:0] tick_q;
   logic [3:0] nbit_q;
   // Short frames keep the one-second holdoff cheap
   assign slot_out  = tick_q[0];
   assign frame_out = (tick_q == 5'h00);
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tick_q <= '0;
         nbit_q <= '0;
         word_out <= '0;
         words_out <= '0;
      end else begin
         tick_q <= tick_q + 5'h01;
         if (clr_in) begin
            nbit_q <= '0;
            words_out <= '0;
         end else if (dl_valid_in) begin
            word_out <= {word_out[14:0], dl_bit_in};
            nbit_q <= nbit_q + 4'h1;
            if (nbit_q == 4'hf) words_out <= words_out + 9'h001;
         end
      end
   end
endmodule // rai_far_end

// ### test/tb_t1_yellow_alarm_generator.sv
// Testbench for the yellow alarm generator.
// Assumes the far-end model supplies strobes and counts patterns.
`timescale 1ns/1ns
module tb_t1_yellow_alarm_generator;
   import rai_pkg::*;
   logic        ref_clk_in, rstn_in, wr_in, rd_in, clr, v;
   logic [15:0] addr_in, word;
   logic [7:0]  wdata_in, rdata_out;
   logic [1:0]  framing_in;
   logic [3:0]  sf_frame_in;
   logic        fs_in, dat_in, b2_in, y_in, yslot, slot, frame;
   logic        fs_out, dat_out, dl_out, dlv, y_out, act;
   logic [8:0]  words;
   logic [31:0] seed = 32'h9b1a, rnd;
   int          error_cnt = 0, n_compared = 0;
   t1_yellow_alarm_generator #(.SECOND_FRAMES(4)) u_t1_yellow_alarm_generator (
      .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .framing_in(framing_in),
      .frame_start_in(frame), .sf_frame_in(sf_frame_in), .fs_bit_in(fs_in),
      .data_bit_in(dat_in), .data_bit_is_b2_in(b2_in), .dl_bit_slot_in(slot),
      .sync_y_bit_in(y_in), .sync_y_slot_in(yslot), .fs_bit_out(fs_out),
      .data_bit_out(dat_out), .dl_bit_out(dl_out), .dl_bit_valid_out(dlv),
      .sync_y_bit_out(y_out), .rai_active_out(act));
   rai_far_end u_rai_far_end (.clk_in(ref_clk_in), .rstn_in(rstn_in), .clr_in(clr),
      .dl_bit_in(dl_out), .dl_valid_in(dlv), .slot_out(slot), .frame_out(frame),
      .word_out(word), .words_out(words));
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [15:0] exp_word(input logic [1:0] sel);
      return (sel == 2'b11) ? PATTERN_ONES : PATTERN_HALF;
   endfunction
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk_in) wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge ref_clk_in) wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk_in) rd_in <= 1'b1;
      addr_in <= a;
      @(posedge ref_clk_in) rd_in <= 1'b0;
      #1 chk_word({8'h00, rdata_out}, {8'h00, e});
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic wait_idle;
      int i;
      for (i = 0; i < 12000 && act !== 1'b0; i++) begin
         @(posedge ref_clk_in);
         #1;
      end
      if (i == 12000) begin
         error_cnt++;
         $display("ERROR %0t alarm never ended", $time);
         complete_run();
      end
   endtask
   task automatic run_esf(input logic [7:0] on, input logic [7:0] off, input logic [1:0] sel);
      @(posedge ref_clk_in) clr <= 1'b1;
      @(posedge ref_clk_in) clr <= 1'b0;
      wr(ALARM_GEN_CTRL_ADDR, on);
      wr(ALARM_GEN_CTRL_ADDR, off);
      settle(4);
      wait_idle();
      chk_word({7'h00, words}, 16'd255);
      chk_word(word, exp_word(sel));
      $display("esf run %h done", on);
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      {rstn_in, wr_in, rd_in, clr, fs_in, addr_in, wdata_in} = '0;
      {framing_in, sf_frame_in, dat_in, b2_in, y_in, yslot} = {FRAMING_SF, 4'hb, 4'hf};
      repeat (2) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      rd(ALARM_GEN_CTRL_ADDR, CTRL_RESET);
      wr(ALARM_GEN_CTRL_ADDR, 8'hf0);
      rd(ALARM_GEN_CTRL_ADDR, 8'hf0);
      rd(16'h0109, 8'h00);
      wr(ALARM_GEN_CTRL_ADDR, 8'h00);
      settle(3);
      chk_bit(dat_out, 1'b1);
      for (int c = 1; c < 4; c++) begin
         wr(ALARM_GEN_CTRL_ADDR, {2'b00, 2'(c), 4'h0});
         settle(3);
         chk_bit(dat_out, c == 2);
         chk_bit(fs_out, c == 2);
      end
      b2_in <= 1'b0;
      repeat (6) begin
         rnd = xs();
         v = rnd[3];
         @(posedge ref_clk_in) dat_in <= v;
         settle(1);
         chk_bit(dat_out, v);
      end
      framing_in <= FRAMING_DATA_MUX;
      for (int c = 0; c < 4; c++) begin
         wr(ALARM_GEN_CTRL_ADDR, {2'b00, 2'(c), 4'h0});
         settle(3);
         chk_bit(y_out, c == 0);
      end
      $display("format test done");
      framing_in <= FRAMING_ESF;
      wr(ALARM_GEN_CTRL_ADDR, 8'h00);
      run_esf(8'h10, 8'h00, 2'b01);
      run_esf(8'h30, 8'h00, 2'b11);
      wr(ALARM_GEN_CTRL_ADDR, 8'h20);
      settle(40);
      chk_bit(act, 1'b1);
      wr(ALARM_GEN_CTRL_ADDR, 8'h00);
      settle(4);
      chk_bit(act, 1'b0);
      wr(ALARM_GEN_CTRL_ADDR, 8'h10);
      settle(8400);
      chk_bit(act, 1'b1);
      wr(ALARM_GEN_CTRL_ADDR, 8'h00);
      wait_idle();
      wr(ALARM_GEN_CTRL_ADDR, 8'h10);
      wr(ALARM_GEN_CTRL_ADDR, 8'h00);
      settle(4000);
      wr(ALARM_GEN_CTRL_ADDR, 8'h10);
      wr(ALARM_GEN_CTRL_ADDR, 8'h00);
      settle(6000);
      chk_bit(act, 1'b1);
      wait_idle();
      run_esf(8'hd0, 8'h90, 2'b01);
      wr(ALARM_GEN_CTRL_ADDR, 8'hd0);
      settle(3);
      chk_bit(act, 1'b0);
      settle(200);
      chk_bit(act, 1'b1);
      settle(8400);
      chk_bit(act, 1'b1);
      wr(ALARM_GEN_CTRL_ADDR, 8'h90);
      wait_idle();
      $display("holdoff test done");
      complete_run();
   end
endmodule // tb_t1_yellow_alarm_generator
